/* rtl/ief_regs.sv */
// interrupt enable and flag registers with request gating toward the cpu core
//
// Our own choice: strobed register access.
`default_nettype none

module ief_regs (
	// clock and reset
	input  wire logic                           ref_clk,
	input  wire logic                           rstn,
	// register port
	input  wire logic [ief_pkg::ADDR_W-1:0]     reg_addr,
	input  wire logic [ief_pkg::DATA_W-1:0]     reg_wdata,
	input  wire logic                           reg_wr,
	input  wire logic                           reg_rd,
	output logic      [ief_pkg::DATA_W-1:0]     reg_rdata,
	// event pulses from timers 0/1 and pins 0/1
	input  wire logic                           timer0_ovf_evt,
	input  wire logic                           timer1_ovf_evt,
	input  wire logic                           pin0_evt,
	input  wire logic                           pin1_evt,
	// vector-taken clears for the hardware-cleared flags
	input  wire logic                           pin0_flag_ack,
	input  wire logic                           timer0_flag_ack,
	input  wire logic                           pin1_flag_ack,
	input  wire logic                           timer1_flag_ack,
	// timer A events
	input  wire logic                           ta_capture_evt,
	input  wire logic                           ta_overflow_evt,
	input  wire logic                           ta_carrier_out,
	// flags held by other peripherals
	input  wire logic                           serial_flag,
	input  wire logic                           timer2_flag,
	input  wire logic                           t2_cmp_capt_flag,
	input  wire logic                           keypad_flag,
	input  wire logic                           pin2_flag,
	input  wire logic                           low_voltage_flag,
	input  wire logic                           pin3_flag,
	input  wire logic                           pin4_flag,
	input  wire logic                           watchdog_flag,
	// timer control
	output logic                                timer0_run,
	output logic                                timer1_run,
	// requests to the cpu core
	output logic      [ief_pkg::IRQ_N-1:0]      irq_req,
	output logic                                irq_any
);

	localparam int unsigned DW = ief_pkg::DATA_W;
	localparam int unsigned FN = ief_pkg::FLAG_N;

	function automatic logic hit(input logic [ief_pkg::ADDR_W-1:0] addr, input logic [ief_pkg::ADDR_W-1:0] off);
		hit = (addr == off);
	endfunction : hit

	logic [DW-1:0] primary_q;
	logic [DW-1:0] extended_q;
	logic [DW-1:0] tcf_ctl_q;
	logic [DW-1:0] taf_ctl_q;
	logic [DW-1:0] rdata_q;
	logic [DW-1:0] rdata_d;
	logic [DW-1:0] tcf_view;
	logic [DW-1:0] taf_view;
	logic [DW-1:0] sum_view;
	logic [FN-1:0] flag_q;
	logic [FN-1:0] flag_set;
	logic [FN-1:0] flag_clr;
	logic [FN-1:0] flag_wmask;
	logic [FN-1:0] flag_wdata;
	logic [ief_pkg::IRQ_N-1:0] src_flag;
	logic [ief_pkg::IRQ_N-1:0] src_en;
	logic          carrier_q;
	logic          carrier_seen_q;
	logic          carrier_rise;
	logic          carrier_fall;
	logic          ta_summary_flag;
	logic          wr_tcf;
	logic          wr_taf;

	assign wr_tcf = reg_wr && hit(reg_addr, ief_pkg::OFF_TIMER_CONFIG_FLAGS);
	assign wr_taf = reg_wr && hit(reg_addr, ief_pkg::OFF_TIMER_A_EVENT_FLAGS);

	// enable registers; reserved bits are kept as plain storage
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			primary_q <= ief_pkg::RST_PRIMARY_SOURCE_ENABLES;
		else if (reg_wr && hit(reg_addr, ief_pkg::OFF_PRIMARY_SOURCE_ENABLES))
			primary_q <= reg_wdata;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			extended_q <= ief_pkg::RST_EXTENDED_SOURCE_ENABLES;
		else if (reg_wr && hit(reg_addr, ief_pkg::OFF_EXTENDED_SOURCE_ENABLES))
			extended_q <= reg_wdata;
	end

	// non-flag bits of the timer config register: run controls and reserved bits
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			tcf_ctl_q <= ief_pkg::RST_TIMER_CONFIG_FLAGS;
		else if (wr_tcf)
			tcf_ctl_q <= reg_wdata;
	end

	assign timer1_run = tcf_ctl_q[ief_pkg::TCF_T1_RUN];
	assign timer0_run = tcf_ctl_q[ief_pkg::TCF_T0_RUN];

	// non-flag bits of the timer A register: local enable and reserved bits
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			taf_ctl_q <= ief_pkg::RST_TIMER_A_EVENT_FLAGS;
		else if (wr_taf)
			taf_ctl_q <= reg_wdata;
	end

	// carrier edge detection; the first sample after reset only primes the history,
	// so a carrier already high at release is not mistaken for a rising edge
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			carrier_q      <= 1'b0;
			carrier_seen_q <= 1'b0;
		end
		else
		begin
			carrier_q      <= ta_carrier_out;
			carrier_seen_q <= 1'b1;
		end
	end

	assign carrier_rise = carrier_seen_q && ta_carrier_out && !carrier_q;
	assign carrier_fall = carrier_seen_q && !ta_carrier_out && carrier_q;

	// hardware sets into the flag bank
	always_comb
	begin
		flag_set                      = '0;
		flag_set[ief_pkg::FB_PIN0]    = pin0_evt;
		flag_set[ief_pkg::FB_TIMER0]  = timer0_ovf_evt;
		flag_set[ief_pkg::FB_PIN1]    = pin1_evt;
		flag_set[ief_pkg::FB_TIMER1]  = timer1_ovf_evt;
		flag_set[ief_pkg::FB_TA_RISE] = carrier_rise;
		flag_set[ief_pkg::FB_TA_FALL] = carrier_fall;
		flag_set[ief_pkg::FB_TA_OVF]  = ta_overflow_evt;
		flag_set[ief_pkg::FB_TA_CAPT] = ta_capture_evt;
	end

	// timer 0/1 and pin 0/1 flags are also cleared when the cpu takes their vector;
	// timer A flags clear only by software
	always_comb
	begin
		flag_clr                     = '0;
		flag_clr[ief_pkg::FB_PIN0]   = pin0_flag_ack;
		flag_clr[ief_pkg::FB_TIMER0] = timer0_flag_ack;
		flag_clr[ief_pkg::FB_PIN1]   = pin1_flag_ack;
		flag_clr[ief_pkg::FB_TIMER1] = timer1_flag_ack;
	end

	// software writes reach the flag bits of whichever register is addressed
	always_comb
	begin
		flag_wmask                      = '0;
		flag_wdata                      = '0;
		flag_wmask[ief_pkg::FB_PIN0]    = wr_tcf;
		flag_wmask[ief_pkg::FB_TIMER0]  = wr_tcf;
		flag_wmask[ief_pkg::FB_PIN1]    = wr_tcf;
		flag_wmask[ief_pkg::FB_TIMER1]  = wr_tcf;
		flag_wmask[ief_pkg::FB_TA_RISE] = wr_taf;
		flag_wmask[ief_pkg::FB_TA_FALL] = wr_taf;
		flag_wmask[ief_pkg::FB_TA_OVF]  = wr_taf;
		flag_wmask[ief_pkg::FB_TA_CAPT] = wr_taf;
		flag_wdata[ief_pkg::FB_PIN0]    = reg_wdata[ief_pkg::TCF_PIN0];
		flag_wdata[ief_pkg::FB_TIMER0]  = reg_wdata[ief_pkg::TCF_T0_OVF];
		flag_wdata[ief_pkg::FB_PIN1]    = reg_wdata[ief_pkg::TCF_PIN1];
		flag_wdata[ief_pkg::FB_TIMER1]  = reg_wdata[ief_pkg::TCF_T1_OVF];
		flag_wdata[ief_pkg::FB_TA_RISE] = reg_wdata[ief_pkg::TAF_RISE];
		flag_wdata[ief_pkg::FB_TA_FALL] = reg_wdata[ief_pkg::TAF_FALL];
		flag_wdata[ief_pkg::FB_TA_OVF]  = reg_wdata[ief_pkg::TAF_OVERFLOW];
		flag_wdata[ief_pkg::FB_TA_CAPT] = reg_wdata[ief_pkg::TAF_CAPTURE];
	end

	ief_flag_bank #(
		.W       (FN)
	) u_flags (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.set_evt (flag_set),
		.hw_clr  (flag_clr),
		.wr_mask (flag_wmask),
		.wr_data (flag_wdata),
		.flag_q  (flag_q)
	);

	// register views as software reads them
	always_comb
	begin
		tcf_view                      = tcf_ctl_q;
		tcf_view[ief_pkg::TCF_T1_OVF] = flag_q[ief_pkg::FB_TIMER1];
		tcf_view[ief_pkg::TCF_T0_OVF] = flag_q[ief_pkg::FB_TIMER0];
		tcf_view[ief_pkg::TCF_PIN1]   = flag_q[ief_pkg::FB_PIN1];
		tcf_view[ief_pkg::TCF_PIN0]   = flag_q[ief_pkg::FB_PIN0];
		taf_view                        = taf_ctl_q;
		taf_view[ief_pkg::TAF_CAPTURE]  = flag_q[ief_pkg::FB_TA_CAPT];
		taf_view[ief_pkg::TAF_OVERFLOW] = flag_q[ief_pkg::FB_TA_OVF];
		taf_view[ief_pkg::TAF_FALL]     = flag_q[ief_pkg::FB_TA_FALL];
		taf_view[ief_pkg::TAF_RISE]     = flag_q[ief_pkg::FB_TA_RISE];
		sum_view                  = '0;
		sum_view[ief_pkg::SUM_TA] = ta_summary_flag;
	end

	// summary has no storage of its own, so it can only fall by clearing the flags
	assign ta_summary_flag = flag_q[ief_pkg::FB_TA_CAPT] | flag_q[ief_pkg::FB_TA_OVF]
	                       | flag_q[ief_pkg::FB_TA_FALL] | flag_q[ief_pkg::FB_TA_RISE];

	// read data stand only in the cycle after the read strobe; unmapped reads return zero
	always_comb
	begin
		rdata_d = '0;
		if (reg_rd)
		begin
			unique case (reg_addr)
				ief_pkg::OFF_TIMER_CONFIG_FLAGS:      rdata_d = tcf_view;
				ief_pkg::OFF_SUMMARY_FLAGS:           rdata_d = sum_view;
				ief_pkg::OFF_PRIMARY_SOURCE_ENABLES:  rdata_d = primary_q;
				ief_pkg::OFF_TIMER_A_EVENT_FLAGS:     rdata_d = taf_view;
				ief_pkg::OFF_EXTENDED_SOURCE_ENABLES: rdata_d = extended_q;
				default:                              rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			rdata_q <= '0;
		else
			rdata_q <= rdata_d;
	end

	assign reg_rdata = rdata_q;

	// per-source flag and enable, in vector order
	always_comb
	begin
		src_flag                         = '0;
		src_flag[ief_pkg::IRQ_PIN0]      = flag_q[ief_pkg::FB_PIN0];
		src_flag[ief_pkg::IRQ_TIMER0]    = flag_q[ief_pkg::FB_TIMER0];
		src_flag[ief_pkg::IRQ_PIN1]      = flag_q[ief_pkg::FB_PIN1];
		src_flag[ief_pkg::IRQ_TIMER1]    = flag_q[ief_pkg::FB_TIMER1];
		src_flag[ief_pkg::IRQ_SERIAL]    = serial_flag;
		src_flag[ief_pkg::IRQ_TIMER_A]   = ta_summary_flag;
		src_flag[ief_pkg::IRQ_TIMER2]    = timer2_flag;
		src_flag[ief_pkg::IRQ_T2_CC]     = t2_cmp_capt_flag;
		src_flag[ief_pkg::IRQ_KEYPAD]    = keypad_flag;
		src_flag[ief_pkg::IRQ_PIN2]      = pin2_flag;
		src_flag[ief_pkg::IRQ_LOW_VOLT]  = low_voltage_flag;
		src_flag[ief_pkg::IRQ_PIN3]      = pin3_flag;
		src_flag[ief_pkg::IRQ_PIN4]      = pin4_flag;
		src_flag[ief_pkg::IRQ_WATCHDOG]  = watchdog_flag;
		src_en                           = '0;
		src_en[ief_pkg::IRQ_PIN0]        = primary_q[ief_pkg::PSE_PIN0];
		src_en[ief_pkg::IRQ_TIMER0]      = primary_q[ief_pkg::PSE_TIMER0];
		src_en[ief_pkg::IRQ_PIN1]        = primary_q[ief_pkg::PSE_PIN1];
		src_en[ief_pkg::IRQ_TIMER1]      = primary_q[ief_pkg::PSE_TIMER1];
		src_en[ief_pkg::IRQ_SERIAL]      = primary_q[ief_pkg::PSE_SERIAL];
		src_en[ief_pkg::IRQ_TIMER_A]     = taf_ctl_q[ief_pkg::TAF_LOCAL_IEN];
		src_en[ief_pkg::IRQ_TIMER2]      = primary_q[ief_pkg::PSE_TIMER2];
		src_en[ief_pkg::IRQ_T2_CC]       = primary_q[ief_pkg::PSE_T2_CMPCAPT];
		src_en[ief_pkg::IRQ_KEYPAD]      = extended_q[ief_pkg::ESE_KEYPAD];
		src_en[ief_pkg::IRQ_PIN2]        = extended_q[ief_pkg::ESE_PIN2];
		src_en[ief_pkg::IRQ_LOW_VOLT]    = extended_q[ief_pkg::ESE_LOW_VOLT];
		src_en[ief_pkg::IRQ_PIN3]        = extended_q[ief_pkg::ESE_PIN3];
		src_en[ief_pkg::IRQ_PIN4]        = extended_q[ief_pkg::ESE_PIN4];
		src_en[ief_pkg::IRQ_WATCHDOG]    = extended_q[ief_pkg::ESE_WATCHDOG];
	end

	// a flag with its enable off stays visible but raises nothing;
	// software-cleared flags repeat until the service routine writes them to 0
	assign irq_req = (src_flag & src_en) & {ief_pkg::IRQ_N{primary_q[ief_pkg::PSE_GLOBAL]}};
	assign irq_any = |irq_req;

endmodule : ief_regs

`default_nettype wire

/* rtl/ief_pkg.sv */
// shared constants for the interrupt enable and flag registers
`default_nettype none

package ief_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;

	// register offsets
	localparam logic [7:0] OFF_TIMER_CONFIG_FLAGS      = 8'h88;
	localparam logic [7:0] OFF_SUMMARY_FLAGS           = 8'h97;
	localparam logic [7:0] OFF_PRIMARY_SOURCE_ENABLES  = 8'hA8;
	localparam logic [7:0] OFF_TIMER_A_EVENT_FLAGS     = 8'hB3;
	localparam logic [7:0] OFF_EXTENDED_SOURCE_ENABLES = 8'hE8;

	// reset values
	localparam logic [7:0] RST_TIMER_CONFIG_FLAGS      = 8'h00;
	localparam logic [7:0] RST_TIMER_A_EVENT_FLAGS     = 8'h00;
	localparam logic [7:0] RST_EXTENDED_SOURCE_ENABLES = 8'h00;
	localparam logic [7:0] RST_PRIMARY_SOURCE_ENABLES  = 8'h00;

	// primary_source_enables fields
	localparam int unsigned PSE_GLOBAL     = 7;
	localparam int unsigned PSE_T2_CMPCAPT = 6;
	localparam int unsigned PSE_TIMER2     = 5;
	localparam int unsigned PSE_SERIAL     = 4;
	localparam int unsigned PSE_TIMER1     = 3;
	localparam int unsigned PSE_PIN1       = 2;
	localparam int unsigned PSE_TIMER0     = 1;
	localparam int unsigned PSE_PIN0       = 0;

	// extended_source_enables fields
	localparam int unsigned ESE_KEYPAD   = 7;
	localparam int unsigned ESE_WATCHDOG = 5;
	localparam int unsigned ESE_LOW_VOLT = 3;
	localparam int unsigned ESE_PIN4     = 2;
	localparam int unsigned ESE_PIN3     = 1;
	localparam int unsigned ESE_PIN2     = 0;

	// timer_config_flags fields
	localparam int unsigned TCF_T1_OVF  = 7;
	localparam int unsigned TCF_T1_RUN  = 6;
	localparam int unsigned TCF_T0_OVF  = 5;
	localparam int unsigned TCF_T0_RUN  = 4;
	localparam int unsigned TCF_PIN1    = 3;
	localparam int unsigned TCF_PIN0    = 1;

	// timer_a_event_flags fields
	localparam int unsigned TAF_CAPTURE   = 4;
	localparam int unsigned TAF_OVERFLOW  = 3;
	localparam int unsigned TAF_FALL      = 2;
	localparam int unsigned TAF_RISE      = 1;
	localparam int unsigned TAF_LOCAL_IEN = 0;

	// summary register field
	localparam int unsigned SUM_TA = 1;

	// index of each hardware-set flag in the flag bank
	localparam int unsigned FLAG_N       = 8;
	localparam int unsigned FB_PIN0      = 0;
	localparam int unsigned FB_TIMER0    = 1;
	localparam int unsigned FB_PIN1      = 2;
	localparam int unsigned FB_TIMER1    = 3;
	localparam int unsigned FB_TA_RISE   = 4;
	localparam int unsigned FB_TA_FALL   = 5;
	localparam int unsigned FB_TA_OVF    = 6;
	localparam int unsigned FB_TA_CAPT   = 7;

	// request vector positions, in vector-number order
	localparam int unsigned IRQ_N        = 14;
	localparam int unsigned IRQ_PIN0     = 0;
	localparam int unsigned IRQ_TIMER0   = 1;
	localparam int unsigned IRQ_PIN1     = 2;
	localparam int unsigned IRQ_TIMER1   = 3;
	localparam int unsigned IRQ_SERIAL   = 4;
	localparam int unsigned IRQ_TIMER_A  = 5;
	localparam int unsigned IRQ_TIMER2   = 6;
	localparam int unsigned IRQ_T2_CC    = 7;
	localparam int unsigned IRQ_KEYPAD   = 8;
	localparam int unsigned IRQ_PIN2     = 9;
	localparam int unsigned IRQ_LOW_VOLT = 10;
	localparam int unsigned IRQ_PIN3     = 11;
	localparam int unsigned IRQ_PIN4     = 12;
	localparam int unsigned IRQ_WATCHDOG = 13;

endpackage : ief_pkg

`default_nettype wire

/* rtl/ief_flag_bank.sv */
// bank of sticky event flags with per-bit software write
`default_nettype none

module ief_flag_bank #(
	parameter int unsigned W = 8
) (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rstn,
	// hardware side
	input  wire logic [W-1:0] set_evt,
	input  wire logic [W-1:0] hw_clr,
	// software side
	input  wire logic [W-1:0] wr_mask,
	input  wire logic [W-1:0] wr_data,
	// flag state
	output logic      [W-1:0] flag_q
);

	logic [W-1:0] flag_d;

	// software write beats a same-cycle hardware set; a hardware set beats a vector clear
	always_comb
	begin
		flag_d = (flag_q & ~hw_clr) | set_evt;
		flag_d = (flag_d & ~wr_mask) | (wr_data & wr_mask);
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			flag_q <= '0;
		else
			flag_q <= flag_d;
	end

endmodule : ief_flag_bank

`default_nettype wire

/* test/ief_checker.sv */
// port-level assertions for the interrupt enable and flag registers
`default_nettype none

module ief_checker (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        rstn,
	// register port
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	// sources
	input wire logic        timer0_ovf_evt,
	input wire logic        serial_flag,
	input wire logic        keypad_flag,
	input wire logic        watchdog_flag,
	// outputs
	input wire logic        timer0_run,
	input wire logic        timer1_run,
	input wire logic [13:0] irq_req,
	input wire logic        irq_any
);
	logic [7:0] pse_q;
	logic [7:0] ese_q;

	// shadows of the two enable registers, rebuilt from the writes seen on the port
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			pse_q <= 8'h00;
		else if (reg_wr && reg_addr == 8'hA8)
			pse_q <= reg_wdata;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			ese_q <= 8'h00;
		else if (reg_wr && reg_addr == 8'hE8)
			ese_q <= reg_wdata;
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	glob_off_a: assert property (!pse_q[7] |-> !irq_any)
		else $error("request raised with global enable clear");
	any_or_a: assert property (irq_any == (|irq_req))
		else $error("summary request differs from request vector");
	serial_req_a: assert property (irq_req[4] == (serial_flag && pse_q[4] && pse_q[7]))
		else $error("serial request gating wrong");
	key_req_a: assert property (irq_req[8] == (keypad_flag && ese_q[7] && pse_q[7]))
		else $error("keypad request gating wrong");
	wdog_req_a: assert property (irq_req[13] == (watchdog_flag && ese_q[5] && pse_q[7]))
		else $error("watchdog request gating wrong");
	run_bits_a: assert property (reg_wr && reg_addr == 8'h88 |=>
		timer1_run == $past(reg_wdata[6]) && timer0_run == $past(reg_wdata[4]))
		else $error("run outputs do not follow config write");
	ovf_req_a: assert property (timer0_ovf_evt && !(reg_wr && reg_addr == 8'h88) |=>
		irq_req[1] == (pse_q[1] && pse_q[7]))
		else $error("timer0 overflow request wrong after event");
	rd_pse_a: assert property (reg_rd && reg_addr == 8'hA8 |=> reg_rdata == $past(pse_q))
		else $error("primary enables read back wrong");
	rd_ese_a: assert property (reg_rd && reg_addr == 8'hE8 |=> reg_rdata == $past(ese_q))
		else $error("extended enables read back wrong");

endmodule : ief_checker

bind ief_regs ief_checker u_chk (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.timer0_ovf_evt, .serial_flag, .keypad_flag, .watchdog_flag, .timer0_run, .timer1_run, .irq_req, .irq_any);

`default_nettype wire

/* test/ief_src_model.sv */
// event source model: held bench commands become one-cycle pulses and level flags
`default_nettype none

module ief_src_model (
	// clock
	input wire logic  ref_clk,
	// commands from the bench
	input wire logic  [9:0] pulse_cmd,
	input wire logic        car_cmd,
	input wire logic  [8:0] lvl_cmd,
	// source outputs
	output var logic  [9:0] pulse_q,
	output var logic        car_q,
	output var logic  [8:0] lvl_q
);
	logic [9:0] prev_q;

	// one pulse per command rise, however long the bench holds it
	always_ff @(posedge ref_clk)
	begin
		pulse_q <= pulse_cmd & ~prev_q;
		prev_q  <= pulse_cmd;
	end

	// levels only move just after an edge, like a real peripheral flop
	always_ff @(posedge ref_clk)
	begin
		car_q <= car_cmd;
		lvl_q <= lvl_cmd;
	end
endmodule : ief_src_model

`default_nettype wire

/* test/testbench.sv */
// self-checking bench for the interrupt enable and flag registers
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk, rstn, reg_wr, reg_rd, car_cmd, car, timer0_run, timer1_run, irq_any;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, a, e;
	logic [13:0] irq_req;
	logic [9:0]  pulse_cmd, ev;
	logic [8:0]  lvl_cmd, lvl;
	logic        rd_d = 1'b0;
	logic [7:0]  rd_q[$];
	logic [7:0]  offs[6] = '{8'h88, 8'hB3, 8'hE8, 8'hA8, 8'h97, 8'h55};
	int          errors = 0, tests_run = 0, cyc = 0;

	ief_src_model src (.ref_clk, .pulse_cmd, .car_cmd, .lvl_cmd, .pulse_q(ev), .car_q(car), .lvl_q(lvl));
	ief_regs dut (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.pin0_evt(ev[0]), .timer0_ovf_evt(ev[1]), .pin1_evt(ev[2]), .timer1_ovf_evt(ev[3]),
		.ta_capture_evt(ev[4]), .ta_overflow_evt(ev[5]), .pin0_flag_ack(ev[6]), .timer0_flag_ack(ev[7]),
		.pin1_flag_ack(ev[8]), .timer1_flag_ack(ev[9]), .ta_carrier_out(car),
		.serial_flag(lvl[0]), .timer2_flag(lvl[1]), .t2_cmp_capt_flag(lvl[2]), .keypad_flag(lvl[3]),
		.pin2_flag(lvl[4]), .low_voltage_flag(lvl[5]), .pin3_flag(lvl[6]), .pin4_flag(lvl[7]),
		.watchdog_flag(lvl[8]), .timer0_run, .timer1_run, .irq_req, .irq_any);

	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test

	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		rd_q.push_back(exp);
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask : rd

	task automatic fire(input logic [9:0] m);
		@(posedge ref_clk);
		pulse_cmd <= m;
		@(posedge ref_clk);
		pulse_cmd <= '0;
	endtask : fire

	task automatic chk_irq(input logic [13:0] exp);
		#1;
		check(irq_req, exp);
	endtask : chk_irq

	// all peripheral flags held high, timer 0/1, pin 0/1 and timer A flags clear
	function automatic logic [13:0] exp_irq(input logic [7:0] p, input logic [7:0] x);
		logic [13:0] r;
		r = {x[5], x[2], x[1], x[3], x[0], x[7], p[6], p[5], 1'b0, p[4], 4'h0};
		return p[7] ? r : 14'h0000;
	endfunction : exp_irq

	// read data stands only in the cycle after the strobe
	always @(posedge ref_clk)
	begin
		if (rd_d)
			check(reg_rdata, rd_q.pop_front());
		rd_d <= reg_rd;
	end

	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			errors++;
			end_of_test();
		end
	end

	initial
	begin
		rstn = 1'b0;
		{reg_wr, reg_rd, car_cmd} = 3'b000;
		{reg_addr, reg_wdata} = 16'h0000;
		pulse_cmd = '0;
		lvl_cmd = '0;
		void'($urandom(32'h65fa5e50));
		repeat (10) @(posedge ref_clk);
		rstn <= 1'b1;
		foreach (offs[i])
			rd(offs[i], 8'h00);
		check({timer1_run, timer0_run, irq_req}, 16'h0000);
		lvl_cmd <= 9'h1FF;
		for (int i = 0; i < 14; i++)
		begin
			a = (i == 0) ? 8'h7F : (i == 1) ? 8'hC0 : 8'($urandom);
			e = (i < 2) ? 8'hFF : 8'($urandom);
			wr(8'hA8, a);
			wr(8'hE8, e);
			chk_irq(exp_irq(a, e));
			rd(8'hA8, a);
			rd(8'hE8, e);
		end
		lvl_cmd <= 9'h000;
		wr(8'hA8, 8'h00);
		wr(8'h88, 8'h50);
		// run outputs update on the edge that took the write, so look after it settles
		#1;
		check({timer1_run, timer0_run}, 2'b11);
		fire(10'h00F);
		rd(8'h88, 8'hFA);
		chk_irq(14'h0000);
		wr(8'hA8, 8'h8F);
		chk_irq(14'h000F);
		fire(10'h080);
		rd(8'h88, 8'hDA);
		chk_irq(14'h000D);
		fire(10'h340);
		rd(8'h88, 8'h50);
		chk_irq(14'h0000);
		// pin 0 set and its ack in one cycle: the set wins
		fire(10'h041);
		rd(8'h88, 8'h52);
		chk_irq(14'h0001);
		wr(8'h88, 8'h00);
		chk_irq(14'h0000);
		// event lands on the same edge as the clearing write
		@(posedge ref_clk);
		pulse_cmd <= 10'h002;
		wr(8'h88, 8'h00);
		pulse_cmd <= '0;
		rd(8'h88, 8'h00);
		wr(8'hA8, 8'h80);
		fire(10'h030);
		car_cmd <= 1'b1;
		repeat (3) @(posedge ref_clk);
		car_cmd <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rd(8'hB3, 8'h1E);
		rd(8'h97, 8'h02);
		chk_irq(14'h0000);
		wr(8'hB3, 8'h1F);
		chk_irq(14'h0020);
		wr(8'h97, 8'h00);
		rd(8'h97, 8'h02);
		wr(8'hB3, 8'hE1);
		rd(8'hB3, 8'hE1);
		rd(8'h97, 8'h00);
		chk_irq(14'h0000);
		repeat (3) @(posedge ref_clk);
		end_of_test();
	end
endmodule : testbench

`default_nettype wire
